// file: imu_status_regs.v
// Identity, error, status and auxiliary mirror registers behind APB
//
// Function
// R1: The fatal flag, bit 0 of the error report, sets on a boot or power fault and clears only by power-on or soft reset.
// R2: Bits 4..1 of the error report carry the internal fault code, zero after reset.
// R3: Error bit 6 sets on a streaming read of an overfilled buffer and clears when the error report is read.
// R4: Error bit 7 sets on an auxiliary two-wire master fault and clears when the error report is read.
// R5: Status bit 2 is one while any auxiliary transfer runs, host- or feature-engine-started.
// R6: Status bit 4 is zero while a command executes and one when the decoder is ready, one after reset.
// R7: Status bit 5 sets on new auxiliary data and clears when any auxiliary mirror byte is read.
// R8: Status bit 6 sets on new angular-rate data and clears when any angular-rate data byte is read.
// R9: Status bit 7 sets on new acceleration data and clears when any acceleration data byte is read.
// R10: Offsets 0x04..0x0B mirror eight consecutive auxiliary registers starting at the configured base.
// R11: Mirror bytes are ordered X, Y, Z, R, each low byte then high byte.
// R12: Offset 0x00 reads a fixed eight-bit identification code.
// R13: The error report sits at offset 0x02 and reads zero after reset.
// R14: Host writes to identity, error, status and mirror registers change nothing.
// R15: The host reads the error report only when it means to consume its read-cleared flags.
`timescale 1ns/1ps
`include "imu_regs_consts.vh"

module imu_status_regs #(
	// Arbitrary identification value
	parameter [7:0] ID_CODE = 8'h5a,
	parameter AW = 12
) (
	input wire REF_CLK,
	input wire SRST,
	input wire SOFT_RESET,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [AW-1:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	input wire FATAL_EVT,
	input wire [3:0] INT_ERR_CODE,
	input wire FIFO_OVF_EVT,
	input wire AUX_ERR_EVT,
	input wire AUX_MAN_BUSY,
	input wire FEAT_ENGINE_BUSY,
	input wire CMD_BUSY,
	input wire ACC_NEW,
	input wire GYR_NEW,
	input wire AUX_NEW,
	input wire ACC_DATA_READ,
	input wire GYR_DATA_READ,
	input wire AUX_WR_EN,
	input wire [7:0] AUX_WR_ADDR,
	input wire [7:0] AUX_WR_DATA,
	output reg [7:0] AUX_BASE,
	output reg IRQ
);

	// Register index from a byte address; misaligned gives all ones
	function [7:0] reg_index;
		input [AW-1:0] addr;
		begin
			if (addr[1:0] != 2'b00 || |addr[AW-1:10])
				reg_index = 8'hff;
			else
				reg_index = addr[9:2];
		end
	endfunction

	// Mirror slot test: true for indices 0x04..0x0b
	function is_mirror;
		input [7:0] idx;
		begin
			is_mirror = (idx >= `IDX_EXT_X_LOW) &&
				(idx <= `IDX_EXT_R_HIGH);
		end
	endfunction

	// R11: slot order X, Y, Z, R, low byte first
	function [2:0] slot_of;
		input [7:0] i;
		begin
			case (i)
			`IDX_EXT_X_LOW:
				slot_of = 3'h0;
			`IDX_EXT_X_HIGH:
				slot_of = 3'h1;
			`IDX_EXT_Y_LOW:
				slot_of = 3'h2;
			`IDX_EXT_Y_HIGH:
				slot_of = 3'h3;
			`IDX_EXT_Z_LOW:
				slot_of = 3'h4;
			`IDX_EXT_Z_HIGH:
				slot_of = 3'h5;
			`IDX_EXT_R_LOW:
				slot_of = 3'h6;
			`IDX_EXT_R_HIGH:
				slot_of = 3'h7;
			default:
				slot_of = 3'h0;
			endcase
		end
	endfunction

	reg [7:0] err_r;
	reg [7:0] err_nxt;
	reg [7:0] flags_r;
	reg [7:0] flags_nxt;
	reg [7:0] mirror_r [0:7];
	reg [`EVT_WIDTH-1:0] evt_r;
	reg [`EVT_WIDTH-1:0] evt_nxt;
	reg [`EVT_WIDTH-1:0] mask_r;
	reg [7:0] base_r;
	reg [31:0] rdata_nxt;
	reg slverr_nxt;
	reg [7:0] cap_r;
	reg [7:0] cap_idx_r;
	reg [7:0] idx;
	wire setup_ph;
	wire done;
	wire rd_done;
	wire wr_done;
	wire clr_err;
	wire clr_evt;
	wire [`EVT_WIDTH-1:0] evt_set;
	wire [7:0] slot;
	wire [7:0] slot_hit;
	wire clr_aux;
	wire wr_mask;
	wire wr_base;
	wire aux_busy;
	wire cmd_ready;
	reg [`EVT_WIDTH-1:0] mask_nxt;
	reg [7:0] base_nxt;

	// Setup phase and completing access phase
	assign setup_ph = PSEL & ~PENABLE;
	assign done = PSEL & PENABLE & PREADY;
	assign rd_done = done & ~PWRITE;
	assign wr_done = done & PWRITE;

	// Read-clear effects are tied to the completing edge, not to setup
	assign clr_err = rd_done & (cap_idx_r == `IDX_ERROR_REPORT);
	assign clr_evt = rd_done & (cap_idx_r == `IDX_EVENT_STATUS);
	assign clr_aux = rd_done & is_mirror(cap_idx_r);

	// R14: only the mask and base registers take writes
	assign wr_mask = wr_done & (cap_idx_r == `IDX_EVENT_MASK);
	assign wr_base = wr_done & (cap_idx_r == `IDX_AUX_BASE);

	// Live status sources, copied into the flags every cycle
	assign aux_busy = AUX_MAN_BUSY | FEAT_ENGINE_BUSY;
	assign cmd_ready = ~CMD_BUSY;

	// Events feeding the interrupt status
	assign evt_set[`EVT_FATAL_BIT] = FATAL_EVT;
	assign evt_set[`EVT_FIFO_BIT] = FIFO_OVF_EVT;
	assign evt_set[`EVT_AUX_ERR_BIT] = AUX_ERR_EVT;
	assign evt_set[`EVT_DRDY_AUX_BIT] = AUX_NEW;
	assign evt_set[`EVT_DRDY_GYR_BIT] = GYR_NEW;
	assign evt_set[`EVT_DRDY_ACC_BIT] = ACC_NEW;

	// Offset of an auxiliary write from the configured base
	assign slot = AUX_WR_ADDR - base_r;

	// Error report next value
	always @*
	begin
		err_nxt = err_r;
		// R1: fatal flag sticky
		if (SOFT_RESET)
			err_nxt[`ERR_FATAL_BIT] = 1'b0;
		else if (FATAL_EVT)
			err_nxt[`ERR_FATAL_BIT] = 1'b1;
		// R2: live fault code
		err_nxt[`ERR_CODE_MSB:`ERR_CODE_LSB] = INT_ERR_CODE;
		// R3: fifo fault read-clear
		// Only bits seen by the host are dropped; a set wins
		if (clr_err && cap_r[`ERR_FIFO_BIT])
			err_nxt[`ERR_FIFO_BIT] = 1'b0;
		if (FIFO_OVF_EVT)
			err_nxt[`ERR_FIFO_BIT] = 1'b1;
		// R4: aux fault read-clear
		if (clr_err && cap_r[`ERR_AUX_BIT])
			err_nxt[`ERR_AUX_BIT] = 1'b0;
		if (AUX_ERR_EVT)
			err_nxt[`ERR_AUX_BIT] = 1'b1;
		err_nxt[5] = 1'b0;
		// Soft reset clears every field, events included
		if (SOFT_RESET)
			err_nxt = `ERR_RESET;
	end

	// Status flags next value
	always @*
	begin
		flags_nxt = 8'h00;
		// R5: busy from either source
		flags_nxt[`FLG_AUX_BUSY_BIT] = aux_busy;
		// R6: ready when no command runs
		flags_nxt[`FLG_CMD_RDY_BIT] = cmd_ready;
		// R7: aux data ready
		flags_nxt[`FLG_DRDY_AUX_BIT] = flags_r[`FLG_DRDY_AUX_BIT];
		if (clr_aux)
			flags_nxt[`FLG_DRDY_AUX_BIT] = 1'b0;
		if (AUX_NEW)
			flags_nxt[`FLG_DRDY_AUX_BIT] = 1'b1;
		// R8: gyro data ready
		flags_nxt[`FLG_DRDY_GYR_BIT] = flags_r[`FLG_DRDY_GYR_BIT];
		if (GYR_DATA_READ)
			flags_nxt[`FLG_DRDY_GYR_BIT] = 1'b0;
		if (GYR_NEW)
			flags_nxt[`FLG_DRDY_GYR_BIT] = 1'b1;
		// R9: accel data ready
		flags_nxt[`FLG_DRDY_ACC_BIT] = flags_r[`FLG_DRDY_ACC_BIT];
		if (ACC_DATA_READ)
			flags_nxt[`FLG_DRDY_ACC_BIT] = 1'b0;
		if (ACC_NEW)
			flags_nxt[`FLG_DRDY_ACC_BIT] = 1'b1;
		if (SOFT_RESET)
			flags_nxt = `FLG_RESET;
	end

	// Interrupt status next value
	always @*
	begin
		evt_nxt = evt_r;
		if (clr_evt)
			evt_nxt = evt_r & ~cap_r[`EVT_WIDTH-1:0];
		evt_nxt = evt_nxt | evt_set;
		if (SOFT_RESET)
			evt_nxt = `EVT_RESET;
	end

	// Read mux, evaluated in the setup phase
	always @*
	begin
		idx = reg_index(PADDR);
		rdata_nxt = 32'h00000000;
		slverr_nxt = 1'b0;
		if (is_mirror(idx))
			// R10: mirror slot by index
			rdata_nxt[7:0] = mirror_r[slot_of(idx)];
		else
			case (idx)
			// R12: fixed identity
			`IDX_DEVICE_IDENTITY:
				rdata_nxt[7:0] = ID_CODE;
			// R13: error report at 0x02
			`IDX_ERROR_REPORT:
				rdata_nxt[7:0] = err_r;
			`IDX_SENSOR_FLAGS:
				rdata_nxt[7:0] = flags_r;
			`IDX_EVENT_STATUS:
				rdata_nxt[`EVT_WIDTH-1:0] = evt_r;
			`IDX_EVENT_MASK:
				rdata_nxt[`EVT_WIDTH-1:0] = mask_r;
			`IDX_AUX_BASE:
				rdata_nxt[7:0] = base_r;
			default:
				slverr_nxt = 1'b1;
			endcase
	end

	// APB handshake: one wait-free access phase per transfer
	always @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end
		else if (setup_ph)
		begin
			PREADY <= 1'b1;
			PSLVERR <= slverr_nxt;
		end
		else if (done)
		begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end
	end

	// Read data and target captured at setup, so a read-clear
	// drops only what the host was actually shown
	always @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			PRDATA <= 32'h00000000;
			cap_r <= 8'h00;
			cap_idx_r <= 8'hff;
		end
		else if (setup_ph)
		begin
			PRDATA <= PWRITE ? 32'h00000000 : rdata_nxt;
			cap_r <= rdata_nxt[7:0];
			cap_idx_r <= reg_index(PADDR);
		end
	end

	// Flags and error report
	always @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			err_r <= `ERR_RESET;
			flags_r <= `FLG_RESET;
		end
		else
		begin
			err_r <= err_nxt;
			flags_r <= flags_nxt;
		end
	end

	// Interrupt status and its level output
	always @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			evt_r <= `EVT_RESET;
			IRQ <= 1'b0;
		end
		else
		begin
			evt_r <= evt_nxt;
			// Next-state view, so a new mask acts on the same edge
			IRQ <= |(evt_nxt & mask_nxt);
		end
	end

	// Writable registers next value
	always @*
	begin
		mask_nxt = mask_r;
		base_nxt = base_r;
		if (SOFT_RESET)
		begin
			mask_nxt = `MASK_RESET;
			base_nxt = `AUX_BASE_RESET;
		end
		else
		begin
			if (wr_mask)
				mask_nxt = PWDATA[`EVT_WIDTH-1:0];
			if (wr_base)
				base_nxt = PWDATA[7:0];
		end
	end

	// Writable registers; the base is also driven out to the link
	always @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			mask_r <= `MASK_RESET;
			base_r <= `AUX_BASE_RESET;
			AUX_BASE <= `AUX_BASE_RESET;
		end
		else
		begin
			mask_r <= mask_nxt;
			base_r <= base_nxt;
			AUX_BASE <= base_nxt;
		end
	end

	// Mirror bytes, one slot per offset from the configured base
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : mirror_slot
			// R10: capture base plus offset
			assign slot_hit[g] = AUX_WR_EN && ({24'h000000, slot} == g);
			always @(posedge REF_CLK)
			begin
				if (SRST || SOFT_RESET)
					mirror_r[g] <= `MIRROR_RESET;
				else if (slot_hit[g])
					mirror_r[g] <= AUX_WR_DATA;
			end
		end
	endgenerate

endmodule // imu_status_regs

// file: imu_regs_consts.vh
// Offsets, field positions, reset values of the status register bank
`ifndef IMU_REGS_CONSTS_VH
`define IMU_REGS_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_DEVICE_IDENTITY 8'h00
`define IDX_ERROR_REPORT 8'h02
`define IDX_SENSOR_FLAGS 8'h03
`define IDX_EXT_X_LOW 8'h04
`define IDX_EXT_X_HIGH 8'h05
`define IDX_EXT_Y_LOW 8'h06
`define IDX_EXT_Y_HIGH 8'h07
`define IDX_EXT_Z_LOW 8'h08
`define IDX_EXT_Z_HIGH 8'h09
`define IDX_EXT_R_LOW 8'h0a
`define IDX_EXT_R_HIGH 8'h0b
`define IDX_EVENT_STATUS 8'h40
`define IDX_EVENT_MASK 8'h41
`define IDX_AUX_BASE 8'h42

// Error report fields
`define ERR_FATAL_BIT 0
`define ERR_CODE_LSB 1
`define ERR_CODE_MSB 4
`define ERR_FIFO_BIT 6
`define ERR_AUX_BIT 7
`define ERR_RESET 8'h00

// Sensor flag fields
`define FLG_AUX_BUSY_BIT 2
`define FLG_CMD_RDY_BIT 4
`define FLG_DRDY_AUX_BIT 5
`define FLG_DRDY_GYR_BIT 6
`define FLG_DRDY_ACC_BIT 7
`define FLG_RESET 8'h10

// Event status / mask layout
`define EVT_FATAL_BIT 0
`define EVT_FIFO_BIT 1
`define EVT_AUX_ERR_BIT 2
`define EVT_DRDY_AUX_BIT 3
`define EVT_DRDY_GYR_BIT 4
`define EVT_DRDY_ACC_BIT 5
`define EVT_WIDTH 6
`define EVT_RESET 6'h00
`define MASK_RESET 6'h00

// Other reset values
`define MIRROR_RESET 8'h00
`define AUX_BASE_RESET 8'h00

`endif

// file: imu_status_regs_monitor.sv
// Port-level checks for the status register bank
`timescale 1ns/1ps
module imu_status_regs_monitor #(
	parameter [7:0] ID_CODE = 8'h5a,
	parameter AW = 12
) (
	input wire REF_CLK,
	input wire SRST,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [AW-1:0] PADDR,
	input wire [31:0] PRDATA,
	input wire PREADY,
	input wire PSLVERR,
	input wire [3:0] INT_ERR_CODE,
	input wire AUX_MAN_BUSY,
	input wire FEAT_ENGINE_BUSY,
	input wire CMD_BUSY
);
	// Decoded index, completed read, either busy source
	wire [7:0] idx = PADDR[9:2];
	wire rd = PREADY && !PWRITE;
	wire busy = AUX_MAN_BUSY | FEAT_ENGINE_BUSY;
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_access;
		PSEL && PENABLE && PREADY;
	endsequence
	// Read data is latched at setup, so inputs count two edges back
	a_ready_once: assert property (s_setup |=> s_access ##1 !PREADY)
		else $error("ready late or long");
	a_id_fixed: assert property (
		rd && idx == 8'h00 |-> PRDATA == {24'h000000, ID_CODE})
		else $error("identity wrong");
	a_err_code: assert property (
		rd && idx == 8'h02 |-> PRDATA[4:1] == $past(INT_ERR_CODE, 2))
		else $error("fault code wrong");
	a_aux_busy: assert property (
		rd && idx == 8'h03 |-> PRDATA[2] == $past(busy, 2))
		else $error("aux busy wrong");
	a_cmd_ready: assert property (
		rd && idx == 8'h03 |-> PRDATA[4] == !$past(CMD_BUSY, 2))
		else $error("command ready wrong");
	a_write_quiet: assert property (
		PREADY && PWRITE |-> PRDATA == 32'h00000000)
		else $error("write returned data");
	a_unmapped_err: assert property (
		PREADY && idx > 8'h42 |-> PSLVERR && PRDATA == 32'h00000000)
		else $error("unmapped not refused");
	a_mapped_ok: assert property (
		PREADY && idx <= 8'h0b && idx != 8'h01 && PADDR[1:0] == 2'b00
		&& PADDR[11:10] == 2'b00
		|-> !PSLVERR)
		else $error("mapped refused");
endmodule // imu_status_regs_monitor

// file: imu_host_model.sv
// Host processor model issuing APB transfers
`timescale 1ns/1ps
module imu_host_model (
	input wire logic clk,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [11:0] paddr = 12'h000,
	output logic [31:0] pwdata = 32'h00000000,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// reads consume flags: caller reads error only on purpose
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Hold the request until ready is sampled
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // imu_host_model

// file: imu_status_regs_tb.sv
// Random and directed bench for the status register bank
`timescale 1ns/1ps
module imu_status_regs_tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [8:0] ev = 9'h000;
	logic [3:0] code = 4'h0;
	logic mb = 1'b0, fb = 1'b0, cb = 1'b0, we = 1'b0;
	logic [7:0] wa = 8'h00, wd = 8'h00, b, ab;
	logic [7:0] mir [8];
	logic [15:0] lf = 16'hc754; // Seed 51028
	logic psel, penable, pwrite, pready, pslverr, e, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int fails = 0;
	int checked = 0;
	initial forever #12.5 clk = ~clk;
	imu_status_regs u_imu_status_regs (.REF_CLK(clk), .SRST(srst),
		.SOFT_RESET(ev[8]), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.FATAL_EVT(ev[0]), .INT_ERR_CODE(code), .FIFO_OVF_EVT(ev[1]),
		.AUX_ERR_EVT(ev[2]), .AUX_MAN_BUSY(mb), .FEAT_ENGINE_BUSY(fb),
		.CMD_BUSY(cb), .ACC_NEW(ev[5]), .GYR_NEW(ev[4]), .AUX_NEW(ev[3]),
		.ACC_DATA_READ(ev[7]), .GYR_DATA_READ(ev[6]), .AUX_WR_EN(we),
		.AUX_WR_ADDR(wa), .AUX_WR_DATA(wd), .AUX_BASE(ab), .IRQ(irq));
	imu_host_model u_imu_host_model (.clk, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr);
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Expected error report from fatal and sticky bits
	function automatic logic [31:0] erx(input logic f, input logic [1:0] s);
		return {24'h000000, s, 1'b0, code, f};
	endfunction
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask
	task rd(input logic [7:0] i);
		u_imu_host_model.xfer(1'b0, {2'b00, i, 2'b00}, 32'h0, q, e);
	endtask
	task wr(input logic [7:0] i, input logic [31:0] d);
		u_imu_host_model.xfer(1'b1, {2'b00, i, 2'b00}, d, q, e);
	endtask
	task pulse(input logic [8:0] m);
		@(posedge clk) ev <= m;
		@(posedge clk) ev <= 9'h000;
	endtask
	task complete_run;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Busy lines wander each cycle to stress the flag latency
	always @(posedge clk)
	begin
		lf <= nx(lf);
		{mb, fb, cb} <= lf[2:0];
	end
	initial
	begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		code <= lf[3:0];
		rd(8'h00);
		chk("identity", q, 32'h5a);
		rd(8'h02);
		chk("error reset", q, erx(1'b0, 2'b00));
		$display("test reset done");
		pulse(9'h007);
		rd(8'h02);
		chk("error set", q, erx(1'b1, 2'b11));
		rd(8'h02);
		chk("error cleared", q, erx(1'b1, 2'b00));
		wr(8'h02, 32'hffffffff);
		rd(8'h02);
		chk("error write", q, erx(1'b1, 2'b00));
		pulse(9'h100);
		rd(8'h02);
		chk("soft reset", q, erx(1'b0, 2'b00));
		$display("test errors done");
		pulse(9'h038);
		rd(8'h03);
		chk("ready set", q & 32'he0, 32'he0);
		pulse(9'h040);
		rd(8'h03);
		chk("rate clear", q & 32'he0, 32'ha0);
		pulse(9'h080);
		rd(8'h03);
		chk("accel clear", q & 32'he0, 32'h20);
		$display("test flags done");
		b = lf[7:0];
		wr(8'h42, {24'h000000, b});
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			we <= 1'b1;
			wa <= b + i[7:0];
			wd <= lf[15:8];
			mir[i] = lf[15:8];
		end
		@(posedge clk);
		we <= 1'b0;
		chk("aux base", {24'h000000, ab}, {24'h000000, b});
		for (int i = 0; i < 8; i++)
		begin
			rd(8'h04 + i[7:0]);
			chk("mirror", q, {24'h000000, mir[i]});
		end
		rd(8'h03);
		chk("aux clear", q & 32'h20, 32'h00);
		$display("test mirror done");
		wr(8'h41, 32'h4);
		pulse(9'h002);
		@(posedge clk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		pulse(9'h004);
		@(posedge clk);
		chk("irq raised", {31'h0, irq}, 32'h1);
		rd(8'h40);
		chk("events", q, 32'h3e);
		@(posedge clk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		rd(8'h50);
		chk("refused", {31'h0, e}, 32'h1);
		$display("test irq done");
		complete_run;
	end
	initial
	begin
		#100000;
		fails++;
		complete_run;
	end
endmodule // imu_status_regs_tb
bind imu_status_regs imu_status_regs_monitor #(.ID_CODE(ID_CODE), .AW(AW))
	u_mon (.REF_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA,
	.PREADY, .PSLVERR, .INT_ERR_CODE, .AUX_MAN_BUSY, .FEAT_ENGINE_BUSY,
	.CMD_BUSY);
